// ==== dcfb_fuse_bank.sv ====
// Configuration fuse bank: AXI4-Lite register file and decoded options
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps

module dcfb_fuse_bank
	import dcfb_pkg::*;
#(
	parameter bit LARGE_MEMORY = 1'b1
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	// AXI4-Lite write address and data
	input  wire logic              i_awvalid,
	output      logic              o_awready,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_wvalid,
	output      logic              o_wready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	// AXI4-Lite write response
	output      logic              o_bvalid,
	input  wire logic              i_bready,
	output      logic [1:0]        o_bresp,
	// AXI4-Lite read
	input  wire logic              i_arvalid,
	output      logic              o_arready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	output      logic              o_rvalid,
	input  wire logic              i_rready,
	output      logic [31:0]       o_rdata,
	output      logic [1:0]        o_rresp,
	// Consumer-side inputs
	input  wire logic              i_supply_low,
	input  wire logic              i_stack_fault,
	input  wire logic              i_soft_watchdog_on,
	input  wire logic [7:0]        i_memory_iface_ctrl,
	input  wire logic [20:0]       i_fetch_addr,
	// Decoded options and derived controls
	output      dcfb_cfg_s         o_cfg,
	output      logic              o_cfg_valid,
	output      logic              o_brownout_reset,
	output      logic              o_stack_reset,
	output      logic              o_watchdog_run,
	output      logic [1:0]        o_bus_wait_count,
	output      logic              o_guard_hit
);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------

	// Shared by read and write paths; byte address is four times index
	function automatic logic [3:0] decode_slot(input logic [23:0] a);
		logic [23:0] idx;

		// Misaligned maps nowhere
		idx = {2'b00, a[23:2]};
		if (a[1:0] != 2'b00)
			decode_slot = 4'h0;
		else if (idx == IDX_CLOCK)
			decode_slot = {1'b1, SLOT_CLOCK};
		else if (idx == IDX_SUPPLY)
			decode_slot = {1'b1, SLOT_SUPPLY};
		else if (idx == IDX_WDOG)
			decode_slot = {1'b1, SLOT_WDOG};
		else if (idx == IDX_MEMORY)
			decode_slot = {1'b1, SLOT_MEMORY};
		else if (idx == IDX_ROUTE)
			decode_slot = {1'b1, SLOT_ROUTE};
		else if (idx == IDX_DEBUG)
			decode_slot = {1'b1, SLOT_DEBUG};
		else if (idx == IDX_GUARD)
			decode_slot = {1'b1, SLOT_GUARD};
		// Status is read-only
		else if (idx == IDX_STATUS)
			decode_slot = {1'b1, SLOT_STATUS};
		else
			decode_slot = 4'h0;
	endfunction

	// Also the erased values
	localparam logic [7:0] MASKS [0:NUM_CFG-1] = '{MASK_CLOCK,
		MASK_SUPPLY, MASK_WDOG, MASK_MEMORY, MASK_ROUTE, MASK_DEBUG,
		MASK_GUARD};

	// ---------------------------------------------------------------
	// Write channel
	// ---------------------------------------------------------------

	// Halves taken early
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0]        w_byte;
	logic              w_lane0;

	// Held half bypasses input
	wire aw_take    = i_awvalid && o_awready;
	wire w_take     = i_wvalid && o_wready;
	wire have_aw    = aw_held || aw_take;
	wire have_w     = w_held || w_take;
	wire do_write   = have_aw && have_w && !o_bvalid;
	// Final address and data
	wire [23:0] wr_addr  = aw_held ? aw_addr : i_awaddr;
	wire [7:0]  wr_byte  = w_held ? w_byte : i_wdata[7:0];
	wire        wr_lane0 = w_held ? w_lane0 : i_wstrb[0];
	wire [3:0]  wr_slot  = decode_slot(wr_addr);

	// Stall while bresp waits
	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready  = !w_held && !o_bvalid;

	// Hold whichever half arrives first until the other one comes
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			aw_held <= have_aw && !do_write;
			w_held  <= have_w && !do_write;
			if (aw_take)
				aw_addr <= i_awaddr;
			if (w_take) begin
				w_byte  <= i_wdata[7:0];
				w_lane0 <= i_wstrb[0];
			end
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_slot[3] ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Configuration bytes
	// ---------------------------------------------------------------

	// Byte per slot
	logic [7:0] cfg_byte [0:NUM_CFG-1];

	// Unprogrammed value is ones in implemented bits, zero elsewhere
	// Used by both loops
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
			// Lane 0 carries the byte
			wire hit = do_write && wr_lane0 && wr_slot[3] &&
				(wr_slot[2:0] == 3'(gi));
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn)
					cfg_byte[gi] <= MASKS[gi];
				else if (hit)
					cfg_byte[gi] <= wr_byte & MASKS[gi];
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Decode of stored bytes into options
	// ---------------------------------------------------------------

	// Bytes by slot
	wire [7:0] b_clk = cfg_byte[SLOT_CLOCK];
	wire [7:0] b_sup = cfg_byte[SLOT_SUPPLY];
	wire [7:0] b_wdg = cfg_byte[SLOT_WDOG];
	wire [7:0] b_mem = cfg_byte[SLOT_MEMORY];
	wire [7:0] b_rte = cfg_byte[SLOT_ROUTE];
	wire [7:0] b_dbg = cfg_byte[SLOT_DEBUG];

	// Raw fields
	wire [2:0] osc_code  = b_clk[OSC_SEL_LSB +: 3];
	wire [1:0] bor_code  = b_sup[BOR_LEVEL_LSB +: 2];
	wire [2:0] ps_code   = b_wdg[WDOG_PS_LSB +: 3];
	wire [1:0] pm_code   = b_mem[PMODE_LSB +: 2];
	wire       route_c1  = b_rte[CAPCOMP2_BIT];
	wire       mcu_mode  = dcfb_pmode_e'(pm_code) == PMODE_MCU;

	// Enum order follows codes
	wire dcfb_osc_e osc_mode = dcfb_osc_e'(osc_code);
	wire pll_on   = osc_mode == OSC_HIGH_SPEED_CRYSTAL_PLL;
	wire osc_port = osc_mode == OSC_RC_PORT ||
		osc_mode == OSC_EXTERNAL_CLOCK_IN_PORT;

	// Trip level in mV
	wire [12:0] bor_mv = (bor_code == 2'b11) ? BOR_MV_11 :
		(bor_code == 2'b10) ? BOR_MV_10 :
		(bor_code == 2'b01) ? BOR_MV_01 : BOR_MV_00;

	// One-hot ratio
	wire [7:0] wdog_ratio = 8'(8'h01 << ps_code);

	// Pin by memory mode
	wire dcfb_route_e route = route_c1 ? ROUTE_PORT_C_BIT1 :
		(mcu_mode ? ROUTE_PORT_E_BIT7 :
		ROUTE_PORT_B_BIT3);

	// Options decoded now
	dcfb_cfg_s next_cfg;
	always_comb begin
		next_cfg = '0;
		next_cfg.main_osc_locked = b_clk[CLOCK_SWITCH_BIT];
		next_cfg.oscillator_select = osc_mode;
		next_cfg.pll_x4 = pll_on;
		next_cfg.second_oscillator_pin_is_port = osc_port;
		next_cfg.brownout_threshold_mv = bor_mv;
		next_cfg.brownout_on = b_sup[BOR_ON_BIT];
		next_cfg.powerup_delay_timer_on = !b_sup[PWRUP_OFF_N_BIT];
		next_cfg.watchdog_ratio = wdog_ratio;
		next_cfg.watchdog_force_on = b_wdg[WDOG_FORCE_BIT];
		next_cfg.bus_wait_from_ctrl = !b_mem[BUS_WAIT_BIT];
		next_cfg.processor_memory_mode = dcfb_pmode_e'(pm_code);
		next_cfg.capcomp_unit2_pin = route;
		next_cfg.debug_owns_port_b_bit6_bit7 = !b_dbg[DEBUG_N_BIT];
		next_cfg.low_volt_prog_permit = b_dbg[LVP_BIT];
		next_cfg.stack_fault_reset_on = b_dbg[STACK_RST_BIT];
		next_cfg.block_protected = ~cfg_byte[SLOT_GUARD];
	end

	// ---------------------------------------------------------------
	// Latch at reset release
	// ---------------------------------------------------------------

	// Captured once after release; later writes wait for next reset
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cfg_valid <= 1'b0;
			o_cfg       <= '0;
		end else if (!o_cfg_valid) begin
			o_cfg_valid <= 1'b1;
			o_cfg       <= next_cfg;
		end
	end

	// Written bytes that differ from what is in force
	wire pending = o_cfg_valid && (next_cfg != o_cfg);

	// ---------------------------------------------------------------
	// Read channel
	// ---------------------------------------------------------------

	// Flags widened before shift so neither drops
	wire [3:0] rd_slot = decode_slot(i_araddr);
	wire [7:0] status  = (8'(o_cfg_valid) << STAT_APPLIED_BIT) |
		(8'(pending) << STAT_PENDING_BIT);
	wire [7:0] rd_byte = (rd_slot[2:0] == SLOT_STATUS) ? status :
		cfg_byte[rd_slot[2:0]];
	// Request taken
	wire       ar_take = i_arvalid && o_arready;

	// One read at a time
	assign o_arready = !o_rvalid;

	// Narrow data in low lanes, upper bits always zero
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h00000000;
			o_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			o_rvalid <= 1'b1;
			o_rdata  <= rd_slot[3] ? {24'h000000, rd_byte} : 32'h00000000;
			o_rresp  <= rd_slot[3] ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Supply comparator synchroniser
	// ---------------------------------------------------------------

	// Sync stages
	logic [2:0] low_sync;
	logic       supply_low;

	// Comparator is asynchronous; change taken when stages two/three agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			low_sync   <= 3'b000;
			supply_low <= 1'b0;
		end else begin
			low_sync <= {low_sync[1:0], i_supply_low};
			if (low_sync[1] == low_sync[2])
				supply_low <= low_sync[2];
		end
	end

	// ---------------------------------------------------------------
	// Protected block lookup
	// ---------------------------------------------------------------

	// Lower by variant
	logic [7:0] in_blk;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_blk
			// Lower follows size
			wire [20:0] lo = LARGE_MEMORY ? BLK_LO_LARGE[gi] :
				BLK_LO_SMALL[gi];
			wire [20:0] hi = LARGE_MEMORY ? BLK_HI_LARGE[gi] :
				BLK_HI_SMALL[gi];
			assign in_blk[gi] = i_fetch_addr >= lo &&
				i_fetch_addr <= hi;
			// Upper blocks fixed
			assign in_blk[gi+4] = i_fetch_addr >= BLK_LO_UPPER[gi] &&
				i_fetch_addr <= BLK_HI_UPPER[gi];
		end
	endgenerate

	// Absent upper blocks rely on guards kept at one
	wire guard_hit = |(in_blk & o_cfg.block_protected);

	// ---------------------------------------------------------------
	// Derived controls, registered
	// ---------------------------------------------------------------

	// Wait only via control
	wire [1:0] wait_cnt = o_cfg.bus_wait_from_ctrl ?
		i_memory_iface_ctrl[MEMCTRL_WAIT_LSB +: 2] : 2'b00;

	// Gated by o_cfg_valid except o_bus_wait_count, held at zero by reset o_cfg; nothing acts before the latch
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_brownout_reset <= 1'b0;
			o_stack_reset    <= 1'b0;
			o_watchdog_run   <= 1'b0;
			o_bus_wait_count <= 2'b00;
			o_guard_hit      <= 1'b0;
		end else begin
			o_brownout_reset <= o_cfg_valid && o_cfg.brownout_on &&
				supply_low;
			o_stack_reset    <= o_cfg_valid &&
				o_cfg.stack_fault_reset_on && i_stack_fault;
			o_watchdog_run   <= o_cfg_valid &&
				(o_cfg.watchdog_force_on || i_soft_watchdog_on);
			o_bus_wait_count <= wait_cnt;
			o_guard_hit      <= o_cfg_valid && guard_hit;
		end
	end

endmodule // dcfb_fuse_bank

// ==== dcfb_fuse_bank_monitor.sv ====
// Port-level property checker for the configuration fuse bank
`timescale 1ns/10ps
module dcfb_fuse_bank_monitor
	import dcfb_pkg::*;
(
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_resetn,
	// Register bus read side
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	// Consumer side
	input wire logic        i_stack_fault,
	input wire logic        i_soft_watchdog_on,
	input wire logic [7:0]  i_memory_iface_ctrl,
	input wire dcfb_cfg_s   o_cfg,
	input wire logic        o_cfg_valid,
	input wire logic        o_brownout_reset,
	input wire logic        o_stack_reset,
	input wire logic        o_watchdog_run,
	input wire logic [1:0]  o_bus_wait_count,
	input wire logic        o_guard_hit
);
	// ---------------------------------------------------------------
	// Sequences and properties
	// ---------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// Read request taken, then a stalled answer
	sequence s_ar_take; i_arvalid && o_arready; endsequence
	sequence s_r_wait; o_rvalid && !i_rready; endsequence

	property p_read_answer;
		s_ar_take |=> o_rvalid && o_rdata[31:8] == 24'h0;
	endproperty
	property p_read_hold; s_r_wait |=> o_rvalid && $stable(o_rdata); endproperty
	property p_cfg_hold; o_cfg_valid |=> o_cfg_valid && $stable(o_cfg); endproperty
	property p_pll;
		o_cfg_valid |-> o_cfg.pll_x4 ==
			(o_cfg.oscillator_select == OSC_HIGH_SPEED_CRYSTAL_PLL);
	endproperty
	property p_osc_pin;
		o_cfg_valid |-> o_cfg.second_oscillator_pin_is_port ==
			(o_cfg.oscillator_select inside {OSC_RC_PORT,
			OSC_EXTERNAL_CLOCK_IN_PORT});
	endproperty
	property p_ratio; o_cfg_valid |-> $onehot(o_cfg.watchdog_ratio); endproperty
	property p_route_int;
		o_cfg_valid && o_cfg.processor_memory_mode == PMODE_MCU
			|-> o_cfg.capcomp_unit2_pin != ROUTE_PORT_B_BIT3;
	endproperty
	property p_route_ext;
		o_cfg_valid && o_cfg.processor_memory_mode != PMODE_MCU
			|-> o_cfg.capcomp_unit2_pin != ROUTE_PORT_E_BIT7;
	endproperty
	property p_watchdog;
		o_cfg_valid |=> o_watchdog_run ==
			($past(o_cfg.watchdog_force_on) || $past(i_soft_watchdog_on));
	endproperty
	property p_stack;
		o_cfg_valid |=> o_stack_reset ==
			($past(o_cfg.stack_fault_reset_on) && $past(i_stack_fault));
	endproperty
	property p_bus_wait;
		o_cfg_valid |=> o_bus_wait_count == ($past(o_cfg.bus_wait_from_ctrl) ?
			$past(i_memory_iface_ctrl[5:4]) : 2'b00);
	endproperty
	property p_bor_off;
		o_cfg_valid && !o_cfg.brownout_on |=> !o_brownout_reset;
	endproperty
	property p_guard_off;
		o_cfg_valid && o_cfg.block_protected == 8'h00 |=> !o_guard_hit;
	endproperty

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_read_answer: assert property (p_read_answer)
		else $error("read answer late or upper bits set");
	a_read_hold: assert property (p_read_hold)
		else $error("read data dropped before accept");
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("decoded options changed after latch");
	a_pll: assert property (p_pll)
		else $error("pll flag does not match oscillator mode");
	a_osc_pin: assert property (p_osc_pin)
		else $error("oscillator pin use does not match mode");
	a_ratio: assert property (p_ratio)
		else $error("watchdog ratio not a power of two");
	a_route_int: assert property (p_route_int)
		else $error("unit2 routed to external-mode pin");
	a_route_ext: assert property (p_route_ext)
		else $error("unit2 routed to internal-mode pin");
	a_watchdog: assert property (p_watchdog)
		else $error("watchdog run wrong");
	a_stack: assert property (p_stack)
		else $error("stack reset wrong");
	a_bus_wait: assert property (p_bus_wait)
		else $error("bus wait count wrong");
	a_bor_off: assert property (p_bor_off)
		else $error("brown-out reset while disabled");
	a_guard_off: assert property (p_guard_off)
		else $error("guard hit with no block protected");
endmodule // dcfb_fuse_bank_monitor

bind dcfb_fuse_bank dcfb_fuse_bank_monitor u_mon (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
	.o_rdata(o_rdata), .i_stack_fault(i_stack_fault),
	.i_soft_watchdog_on(i_soft_watchdog_on),
	.i_memory_iface_ctrl(i_memory_iface_ctrl), .o_cfg(o_cfg),
	.o_cfg_valid(o_cfg_valid), .o_brownout_reset(o_brownout_reset),
	.o_stack_reset(o_stack_reset), .o_watchdog_run(o_watchdog_run),
	.o_bus_wait_count(o_bus_wait_count), .o_guard_hit(o_guard_hit));

// ==== dcfb_fuse_bank_test.sv ====
// Self-checking testbench for the configuration fuse bank
`timescale 1ns/10ps
module dcfb_fuse_bank_test import dcfb_pkg::*;;
	// ---------------------------------------------------------------
	// Signals and tables
	// ---------------------------------------------------------------
	logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, cfg_valid;
	logic        supply_low, stack_fault, soft_wd;
	logic        bor_rst, stk_rst, wd_run, guard_hit;
	logic [23:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, bus_wait, rsp;
	logic [7:0]  mem_ctrl;
	logic [20:0] fetch_addr;
	dcfb_cfg_s   cfg;
	int          n_mismatch, tests_run;
	logic [23:0] idx_tab [7] = '{IDX_CLOCK, IDX_SUPPLY, IDX_WDOG,
		IDX_MEMORY, IDX_ROUTE, IDX_DEBUG, IDX_GUARD};
	logic [7:0]  rst_tab [7] = '{8'h27, 8'h0F, 8'h0F, 8'h83, 8'h01,
		8'h85, 8'hFF};
	logic [7:0]  wr_tab [7] = '{8'h20, 8'hF0, 8'hFF, 8'h7C, 8'hFF,
		8'h7A, 8'hF5};
	logic [7:0]  rb_tab [7] = '{8'h20, 8'h00, 8'h0F, 8'h00, 8'h01,
		8'h00, 8'hF5};

	// Device under test, larger memory variant
	dcfb_fuse_bank #(.LARGE_MEMORY(1'b1)) uut (
		.i_clk(clk), .i_resetn(resetn),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
		.i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
		.o_rdata(rdata), .o_rresp(rresp), .i_supply_low(supply_low),
		.i_stack_fault(stack_fault), .i_soft_watchdog_on(soft_wd),
		.i_memory_iface_ctrl(mem_ctrl), .i_fetch_addr(fetch_addr),
		.o_cfg(cfg), .o_cfg_valid(cfg_valid), .o_brownout_reset(bor_rst),
		.o_stack_reset(stk_rst), .o_watchdog_run(wd_run),
		.o_bus_wait_count(bus_wait), .o_guard_hit(guard_hit));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Byte address of an index
	function automatic logic [23:0] ba(input logic [23:0] idx);
		return idx << 2;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One write; each half released when taken
	task automatic bus_wr(input logic [23:0] a, input logic [7:0] d,
		output logic [1:0] r);
		r = 2'b01;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h0, d};
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
	endtask

	// One read; rready held until answered
	task automatic bus_rd(input logic [23:0] a, output logic [31:0] d,
		output logic [1:0] r);
		d = '1;
		r = 2'b01;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values;
		for (int i = 0; i < 7; i++) begin
			bus_rd(ba(idx_tab[i]), rd, rsp);
			chk("unprog read", {24'h0, rst_tab[i]}, rd);
			chk("read resp", RESP_OKAY, rsp);
		end
		bus_rd(ba(IDX_STATUS), rd, rsp);
		chk("status", 32'h1, rd);
		$display("test reset_values done");
	endtask

	task automatic t_decode;
		chk("osc lock", 1, cfg.main_osc_locked);
		chk("osc mode", OSC_RC_PORT, cfg.oscillator_select);
		chk("osc pin", 1, cfg.second_oscillator_pin_is_port);
		chk("pll", 0, cfg.pll_x4);
		chk("bor mv", BOR_MV_11, cfg.brownout_threshold_mv);
		chk("bor on", 1, cfg.brownout_on);
		chk("pwrup on", 0, cfg.powerup_delay_timer_on);
		chk("wd ratio", 128, cfg.watchdog_ratio);
		chk("wd force", 1, cfg.watchdog_force_on);
		chk("bus wait src", 0, cfg.bus_wait_from_ctrl);
		chk("pmode", PMODE_MCU, cfg.processor_memory_mode);
		chk("unit2 pin", ROUTE_PORT_C_BIT1, cfg.capcomp_unit2_pin);
		chk("debug pins", 0, cfg.debug_owns_port_b_bit6_bit7);
		chk("lvp", 1, cfg.low_volt_prog_permit);
		chk("stack rst on", 1, cfg.stack_fault_reset_on);
		chk("guards", 0, cfg.block_protected);
		chk("cfg valid", 1, cfg_valid);
		$display("test decode done");
	endtask

	task automatic t_consumers;
		logic [20:0] fa [5] = '{21'h000000, 21'h000200, 21'h003FFF,
			21'h00C000, 21'h01FFFF};
		@(posedge clk);
		soft_wd <= 1'b0;
		mem_ctrl <= 8'h30;
		stack_fault <= 1'b1;
		supply_low <= 1'b1;
		repeat (8) @(posedge clk);
		chk("wd run", 1, wd_run);
		chk("bus wait", 0, bus_wait);
		chk("stack rst", 1, stk_rst);
		chk("bor rst", 1, bor_rst);
		stack_fault <= 1'b0;
		supply_low <= 1'b0;
		repeat (8) @(posedge clk);
		chk("stack rst off", 0, stk_rst);
		chk("bor rst off", 0, bor_rst);
		for (int i = 0; i < 5; i++) begin
			fetch_addr <= fa[i];
			repeat (2) @(posedge clk);
			chk("guard hit", 0, guard_hit);
		end
		$display("test consumers done");
	endtask

	task automatic t_write_back;
		for (int i = 0; i < 7; i++) begin
			bus_wr(ba(idx_tab[i]), wr_tab[i], rsp);
			chk("write resp", RESP_OKAY, rsp);
			bus_rd(ba(idx_tab[i]), rd, rsp);
			chk("readback", {24'h0, rb_tab[i]}, rd);
		end
		chk("upper guards", 4'hF, rd[7:4]);
		bus_wr(ba(IDX_STATUS), 8'h00, rsp);
		chk("status wr", RESP_OKAY, rsp);
		bus_rd(ba(IDX_STATUS), rd, rsp);
		chk("pending", 32'h3, rd);
		chk("osc held", OSC_RC_PORT, cfg.oscillator_select);
		chk("guard held", 0, cfg.block_protected);
		bus_wr(24'hC00000, 8'h00, rsp);
		chk("unmapped wr", RESP_SLVERR, rsp);
		bus_rd(24'hC00000, rd, rsp);
		chk("unmapped rd", RESP_SLVERR, rsp);
		chk("unmapped data", 32'h0, rd);
		bus_rd(ba(IDX_CLOCK) + 24'h1, rd, rsp);
		chk("misaligned rd", RESP_SLVERR, rsp);
		$display("test write_back done");
	endtask

	// Mid-run reset restores unprogrammed bytes
	task automatic t_rereset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("valid in reset", 0, cfg_valid);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus_rd(ba(idx_tab[i]), rd, rsp);
			chk("reread", {24'h0, rst_tab[i]}, rd);
		end
		bus_rd(ba(IDX_STATUS), rd, rsp);
		chk("status again", 32'h1, rd);
		$display("test rereset done");
	endtask

	// ---------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ---------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{supply_low, stack_fault, soft_wd} = '0;
		{awaddr, araddr, wdata, mem_ctrl, fetch_addr} = '0;
		wstrb = 4'hF;
		n_mismatch = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_reset_values();
		t_decode();
		t_consumers();
		t_write_back();
		t_rereset();
		final_report();
	end

	// Hang guard
	initial begin
		#(40 * 20000);
		n_mismatch++;
		$display("ERROR watchdog expired");
		final_report();
	end
endmodule // dcfb_fuse_bank_test

// ==== dcfb_pkg.sv ====
// Constants, field layouts and carrier types of the configuration fuse bank
package dcfb_pkg;

	// ---------------------------------------------------------------
	// Register indices and byte addresses (byte address = 4 x index)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam logic [23:0] IDX_CLOCK  = 24'h300001;
	localparam logic [23:0] IDX_SUPPLY = 24'h300002;
	localparam logic [23:0] IDX_WDOG   = 24'h300003;
	localparam logic [23:0] IDX_MEMORY = 24'h300004;
	localparam logic [23:0] IDX_ROUTE  = 24'h300005;
	localparam logic [23:0] IDX_DEBUG  = 24'h300006;
	localparam logic [23:0] IDX_GUARD  = 24'h300008;
	localparam logic [23:0] IDX_STATUS = 24'h300010;

	// Slot numbers inside the bank
	localparam int NUM_CFG = 7;
	localparam logic [2:0] SLOT_CLOCK  = 3'h0;
	localparam logic [2:0] SLOT_SUPPLY = 3'h1;
	localparam logic [2:0] SLOT_WDOG   = 3'h2;
	localparam logic [2:0] SLOT_MEMORY = 3'h3;
	localparam logic [2:0] SLOT_ROUTE  = 3'h4;
	localparam logic [2:0] SLOT_DEBUG  = 3'h5;
	localparam logic [2:0] SLOT_GUARD  = 3'h6;
	localparam logic [2:0] SLOT_STATUS = 3'h7;

	// Implemented bits; unprogrammed value is all ones in these bits
	localparam logic [7:0] MASK_CLOCK  = 8'h27;
	localparam logic [7:0] MASK_SUPPLY = 8'h0F;
	localparam logic [7:0] MASK_WDOG   = 8'h0F;
	localparam logic [7:0] MASK_MEMORY = 8'h83;
	localparam logic [7:0] MASK_ROUTE  = 8'h01;
	localparam logic [7:0] MASK_DEBUG  = 8'h85;
	localparam logic [7:0] MASK_GUARD  = 8'hFF;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CLOCK_SWITCH_BIT = 5;
	localparam int OSC_SEL_LSB      = 0;
	localparam int BOR_LEVEL_LSB    = 2;
	localparam int BOR_ON_BIT       = 1;
	localparam int PWRUP_OFF_N_BIT  = 0;
	localparam int WDOG_PS_LSB      = 1;
	localparam int WDOG_FORCE_BIT   = 0;
	localparam int BUS_WAIT_BIT     = 7;
	localparam int PMODE_LSB        = 0;
	localparam int CAPCOMP2_BIT     = 0;
	localparam int DEBUG_N_BIT      = 7;
	localparam int LVP_BIT          = 2;
	localparam int STACK_RST_BIT    = 0;
	localparam int MEMCTRL_WAIT_LSB = 4;
	localparam int STAT_APPLIED_BIT = 0;
	localparam int STAT_PENDING_BIT = 1;

	// Brown-out trip levels in millivolts, by level code
	localparam logic [12:0] BOR_MV_11 = 13'h09C4;
	localparam logic [12:0] BOR_MV_10 = 13'h0A8C;
	localparam logic [12:0] BOR_MV_01 = 13'h1068;
	localparam logic [12:0] BOR_MV_00 = 13'h1194;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// Protected block bounds, 21-bit program addresses
	// ---------------------------------------------------------------
	localparam logic [20:0] BLK_LO_SMALL [0:3] = '{21'h000800,
		21'h002000, 21'h004000, 21'h006000};
	localparam logic [20:0] BLK_HI_SMALL [0:3] = '{21'h001FFF,
		21'h003FFF, 21'h005FFF, 21'h007FFF};
	localparam logic [20:0] BLK_LO_LARGE [0:3] = '{21'h000200,
		21'h004000, 21'h008000, 21'h00C000};
	localparam logic [20:0] BLK_HI_LARGE [0:3] = '{21'h003FFF,
		21'h007FFF, 21'h00BFFF, 21'h00FFFF};
	localparam logic [20:0] BLK_LO_UPPER [0:3] = '{21'h010000,
		21'h014000, 21'h018000, 21'h01C000};
	localparam logic [20:0] BLK_HI_UPPER [0:3] = '{21'h013FFF,
		21'h017FFF, 21'h01BFFF, 21'h01FFFF};

	// ---------------------------------------------------------------
	// Modes and carrier
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL,
		OSC_MEDIUM_CRYSTAL,
		OSC_HIGH_SPEED_CRYSTAL,
		OSC_RC_CLKOUT,
		OSC_EXTERNAL_CLOCK_IN_CLKOUT,
		OSC_EXTERNAL_CLOCK_IN_PORT,
		OSC_HIGH_SPEED_CRYSTAL_PLL,
		OSC_RC_PORT
	} dcfb_osc_e;

	typedef enum logic [1:0] {
		PMODE_EXTENDED_MCU,
		PMODE_MPU_BOOT,
		PMODE_MPU,
		PMODE_MCU
	} dcfb_pmode_e;

	typedef enum logic [1:0] {
		ROUTE_PORT_C_BIT1,
		ROUTE_PORT_E_BIT7,
		ROUTE_PORT_B_BIT3
	} dcfb_route_e;

	typedef struct packed {
		logic        main_osc_locked;
		dcfb_osc_e   oscillator_select;
		logic        pll_x4;
		logic        second_oscillator_pin_is_port;
		logic [12:0] brownout_threshold_mv;
		logic        brownout_on;
		logic        powerup_delay_timer_on;
		logic [7:0]  watchdog_ratio;
		logic        watchdog_force_on;
		logic        bus_wait_from_ctrl;
		dcfb_pmode_e processor_memory_mode;
		dcfb_route_e capcomp_unit2_pin;
		logic        debug_owns_port_b_bit6_bit7;
		logic        low_volt_prog_permit;
		logic        stack_fault_reset_on;
		logic [7:0]  block_protected;
	} dcfb_cfg_s;

endpackage
